// [design/can_rx_map.vh]
// constants shared by the receive-side dlc, mirror and timestamp logic
`ifndef CAN_RX_MAP_VH
`define CAN_RX_MAP_VH

// field widths
`define DLC_W          4
`define ID_W           29
`define DATA_BYTES     8
`define DATA_W         64
`define STAMP_W        16
`define DIV_W          4
`define CHAN_N         4
`define CHAN_SEL_W     2

// stored record layout {stamp, id, own, dlc, data}
`define REC_W          114
`define REC_DATA_LSB   0
`define REC_DLC_LSB    64
`define REC_OWN_BIT    68
`define REC_ID_LSB     69
`define REC_STAMP_LSB  98

// fifo in the store path
`define FIFO_DEPTH     16
`define FIFO_AW        4

// reset values, dlc saturation limit and pad byte
`define STAMP_RST      16'h0000
`define DIV_RST        4'h0
`define DLC_ZERO       4'h0
`define DLC_MAX_BYTES  4'h8
`define BYTE_ZERO      8'h00

`endif

// [design/rx_store_fifo.v]
// parameterised fifo with a registered output stage
`timescale 1ns/1ps
module rx_store_fifo #(
    parameter WIDTH = 114,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    localparam [AW:0] FULL_COUNT = DEPTH;

    // full is honest: the output register is extra, not counted here
    assign inReady = (count != FULL_COUNT);
    assign push    = inValid && inReady;
    assign pop     = (!outValid || outReady) && (count != {(AW+1){1'b0}});

    // storage write
    always @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    // pointers, occupancy and output stage
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr    <= {AW{1'b0}};
            rdPtr    <= {AW{1'b0}};
            count    <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wrPtr <= wrPtr + 1'b1;
            if (pop)
            begin
                rdPtr   <= rdPtr + 1'b1;
                outData <= mem[rdPtr];
            end
            if (!outValid || outReady)
                outValid <= pop;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // rx_store_fifo

// [design/can_rx_dlc_mirror_timestamp.v]
// receive-side dlc filter, dlc replacement, mirror selection, clock and timestamp
`timescale 1ns/1ps
`include "can_rx_map.vh"
module can_rx_dlc_mirror_timestamp (
    input  wire                      clk,
    input  wire                      sys_rst,
    input  wire                      dlcCheckEnable,
    input  wire                      dlcReplaceEnable,
    input  wire                      mirrorEnable,
    input  wire                      canClockSourceSelect,
    input  wire                      xinCanClk,
    input  wire                      mainCanClk,
    output reg                       canModuleClock,
    input  wire                      tsSourceSel,
    input  wire [`DIV_W-1:0]         tsDivRatio,
    input  wire [`CHAN_SEL_W-1:0]    tsChannelSel,
    input  wire [`CHAN_N-1:0]        bitTimeTick,
    input  wire [`CHAN_N-1:0]        chanResetMode,
    input  wire [`CHAN_N-1:0]        chanHaltMode,
    input  wire                      sofPulse,
    output reg  [`STAMP_W-1:0]       tsCount,
    input  wire                      frameValid,
    output reg                       frameReady,
    input  wire                      frameOwn,
    input  wire [`ID_W-1:0]          frameId,
    input  wire [`DLC_W-1:0]         frameDlc,
    input  wire [`DATA_W-1:0]        frameData,
    input  wire [`DLC_W-1:0]         ruleDlc,
    input  wire                      ruleOwnMessageSelect,
    output reg                       dlcError,
    output reg                       ruleMiss,
    output wire                      storeValid,
    input  wire                      storeReady,
    output wire [`STAMP_W-1:0]       storeStamp,
    output wire [`ID_W-1:0]          storeId,
    output wire                      storeOwn,
    output wire [`DLC_W-1:0]         storeDlc,
    output wire [`DATA_W-1:0]        storeData
);

    // ********************************************************
    // decode helpers
    // ********************************************************

    // classic frames carry at most eight bytes, larger codes saturate
    function [3:0] dlcBytes;
        input [`DLC_W-1:0] dlc;
        begin
            if (dlc > `DLC_MAX_BYTES)
                dlcBytes = `DLC_MAX_BYTES;
            else
                dlcBytes = dlc;
        end
    endfunction

    // ********************************************************
    // can module clock selection
    // ********************************************************

    // both clock pins are foreign, so each passes two flops first
    wire [1:0] clkPin;
    reg  [1:0] clkMeta;
    reg  [1:0] clkSync;

    assign clkPin = {mainCanClk, xinCanClk};

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1)
        begin : g_clk_sync
            always @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    clkMeta[p] <= 1'b0;
                    clkSync[p] <= 1'b0;
                end
                else
                begin
                    clkMeta[p] <= clkPin[p];
                    clkSync[p] <= clkMeta[p];
                end
            end
        end
    endgenerate

    // sampled view only; a real glitch-free clock mux sits in the clock tree
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            canModuleClock <= 1'b0;
        else
            canModuleClock <= canClockSourceSelect ? clkSync[1] : clkSync[0];
    end

    // ********************************************************
    // timestamp counter
    // ********************************************************

    reg                 halfPclk;
    reg  [`DIV_W-1:0]   divCount;
    reg  [`STAMP_W-1:0] sofStamp;
    wire                srcTick;
    wire                chanStopped;
    wire                tsRun;

    // half of the peripheral clock as a one-cycle tick every other edge
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            halfPclk <= 1'b0;
        else
            halfPclk <= ~halfPclk;
    end

    assign srcTick     = tsSourceSel ? bitTimeTick[tsChannelSel] : halfPclk;
    assign chanStopped = chanResetMode[tsChannelSel] | chanHaltMode[tsChannelSel];
    assign tsRun       = srcTick && !(tsSourceSel && chanStopped);

    // divide by ratio plus one, then advance the counter
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divCount <= `DIV_RST;
            tsCount  <= `STAMP_RST;
        end
        else if (tsRun)
        begin
            if (divCount >= tsDivRatio)
            begin
                divCount <= `DIV_RST;
                tsCount  <= tsCount + 1'b1;
            end
            else
            begin
                divCount <= divCount + 1'b1;
            end
        end
    end

    // value before any same-cycle increment is the one captured
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sofStamp <= `STAMP_RST;
        else if (sofPulse)
            sofStamp <= tsCount;
    end

    // ********************************************************
    // frame intake and evaluation
    // ********************************************************

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EVAL = 2'b10;

    reg [1:0]           state;
    reg                 heldOwn;
    reg [`ID_W-1:0]     heldId;
    reg [`DLC_W-1:0]    heldDlc;
    reg [`DATA_W-1:0]   heldData;
    reg [`DLC_W-1:0]    heldRuleDlc;
    reg                 heldRuleOwn;
    reg [`STAMP_W-1:0]  heldStamp;
    reg                 heldCheck;
    reg                 heldReplace;
    reg                 heldMirror;

    wire                takeFrame;
    wire                ruleHit;
    wire                useCheck;
    wire                dlcPass;
    wire                doReplace;
    wire [`DLC_W-1:0]   outDlc;
    wire [`DATA_W-1:0]  outData;
    wire [3:0]          ruleBytes;
    wire                wantStore;
    wire                fifoReady;
    wire                fifoPush;
    wire [`REC_W-1:0]   record;

    assign takeFrame = frameValid && frameReady;

    // mirror decision: own select must equal the frame's origin,
    // and with mirror off only foreign frames meet plain rules
    // own frames only while mirroring
    assign ruleHit = heldMirror ? (heldRuleOwn == heldOwn) : (!heldRuleOwn && !heldOwn);

    assign useCheck  = heldCheck && (heldRuleDlc != `DLC_ZERO);
    assign dlcPass   = !useCheck || (heldDlc >= heldRuleDlc);
    assign doReplace = useCheck && heldReplace;
    assign outDlc    = doReplace ? heldRuleDlc : heldDlc;
    assign ruleBytes = dlcBytes(heldRuleDlc);

    genvar b;
    generate
        for (b = 0; b < `DATA_BYTES; b = b + 1)
        begin : g_byte_pad
            localparam [3:0] BIDX = b;
            assign outData[8*b+7:8*b] = (doReplace && (BIDX >= ruleBytes)) ?
                                        `BYTE_ZERO : heldData[8*b+7:8*b];
        end
    endgenerate

    assign wantStore = ruleHit && dlcPass;
    assign fifoPush  = (state == ST_EVAL) && wantStore;
    assign record    = {heldStamp, heldId, heldOwn, outDlc, outData};

    // configuration is latched with the frame so mid-frame writes cannot tear it
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            heldOwn     <= 1'b0;
            heldId      <= {`ID_W{1'b0}};
            heldDlc     <= `DLC_ZERO;
            heldData    <= {`DATA_W{1'b0}};
            heldRuleDlc <= `DLC_ZERO;
            heldRuleOwn <= 1'b0;
            heldStamp   <= `STAMP_RST;
            heldCheck   <= 1'b0;
            heldReplace <= 1'b0;
            heldMirror  <= 1'b0;
        end
        else if (takeFrame)
        begin
            heldOwn     <= frameOwn;
            heldId      <= frameId;
            heldDlc     <= frameDlc;
            heldData    <= frameData;
            heldRuleDlc <= ruleDlc;
            heldRuleOwn <= ruleOwnMessageSelect;
            heldStamp   <= sofStamp;
            heldCheck   <= dlcCheckEnable;
            heldReplace <= dlcReplaceEnable;
            heldMirror  <= mirrorEnable;
        end
    end

    // two-state sequencer; evaluation waits while the fifo is full
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state      <= ST_IDLE;
            frameReady <= 1'b1;
            dlcError   <= 1'b0;
            ruleMiss   <= 1'b0;
        end
        else
        begin
            dlcError <= 1'b0;
            ruleMiss <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (takeFrame)
                    begin
                        frameReady <= 1'b0;
                        state      <= ST_EVAL;
                    end
                end
                ST_EVAL:
                begin
                    if (!ruleHit)
                    begin
                        ruleMiss   <= 1'b1;
                        frameReady <= 1'b1;
                        state      <= ST_IDLE;
                    end
                    else if (!dlcPass)
                    begin
                        dlcError   <= 1'b1;
                        frameReady <= 1'b1;
                        state      <= ST_IDLE;
                    end
                    else if (fifoReady)
                    begin
                        frameReady <= 1'b1;
                        state      <= ST_IDLE;
                    end
                end
                default:
                begin
                    frameReady <= 1'b1;
                    state      <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // store fifo
    // ********************************************************

    wire [`REC_W-1:0] headRecord;

    rx_store_fifo #(
        .WIDTH (`REC_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_store_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (fifoPush),
        .inReady  (fifoReady),
        .inData   (record),
        .outValid (storeValid),
        .outReady (storeReady),
        .outData  (headRecord)
    );

    // record fields straight off the fifo output register
    assign storeData  = headRecord[`REC_DATA_LSB +: `DATA_W];
    assign storeDlc   = headRecord[`REC_DLC_LSB +: `DLC_W];
    assign storeOwn   = headRecord[`REC_OWN_BIT];
    assign storeId    = headRecord[`REC_ID_LSB +: `ID_W];
    assign storeStamp = headRecord[`REC_STAMP_LSB +: `STAMP_W];

endmodule // can_rx_dlc_mirror_timestamp

// [test/can_rx_props.sv]
// assertion checker for the receive dlc, mirror and timestamp block
`timescale 1ns/1ps
module can_rx_props (
    input wire        clk,
    input wire        sys_rst,
    input wire        dlcCheckEnable,
    input wire        mirrorEnable,
    input wire        canClockSourceSelect,
    input wire        xinCanClk,
    input wire        mainCanClk,
    input wire        canModuleClock,
    input wire        tsSourceSel,
    input wire [3:0]  tsDivRatio,
    input wire [1:0]  tsChannelSel,
    input wire [3:0]  bitTimeTick,
    input wire [3:0]  chanResetMode,
    input wire [3:0]  chanHaltMode,
    input wire [15:0] tsCount,
    input wire        frameValid,
    input wire        frameReady,
    input wire        frameOwn,
    input wire [3:0]  frameDlc,
    input wire [3:0]  ruleDlc,
    input wire        ruleOwnMessageSelect,
    input wire        dlcError,
    input wire        ruleMiss,
    input wire        storeValid,
    input wire        storeReady,
    input wire [63:0] storeData
);
    // ****
    // properties
    // ****
    // mirror selection lets this rule see the frame
    wire selOk = mirrorEnable ? frameOwn == ruleOwnMessageSelect
                              : !(frameOwn | ruleOwnMessageSelect);
    wire stopped = chanResetMode[tsChannelSel] | chanHaltMode[tsChannelSel];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_take;
        frameValid && frameReady;
    endsequence
    sequence s_halted;
        (tsSourceSel && stopped) [*2];
    endsequence
    a_short_dlc_drop: assert property (s_take ##0 (selOk && dlcCheckEnable && ruleDlc != 4'h0
        && frameDlc < ruleDlc) |-> ##2 (dlcError && !ruleMiss)) else $error("short frame kept");
    a_select_miss: assert property (s_take ##0 !selOk |-> ##2 (ruleMiss && !dlcError))
        else $error("mirror selection not refused");
    a_passing_frame: assert property (s_take ##0 (selOk && (!dlcCheckEnable
        || frameDlc >= ruleDlc)) |-> ##2 !(dlcError || ruleMiss)) else $error("good frame dropped");
    a_intake_busy: assert property (s_take |=> !frameReady) else $error("ready stayed high");
    a_stamp_halted: assert property (s_halted |-> $stable(tsCount))
        else $error("stamp moved while channel stopped");
    a_bit_tick_count: assert property ((tsSourceSel && !stopped && tsDivRatio == 4'h0
        && bitTimeTick[tsChannelSel]) |=> tsCount == $past(tsCount) + 16'h0001)
        else $error("stamp missed a bit tick");
    a_half_pclk_run: assert property ((!sys_rst && !tsSourceSel && tsDivRatio == 4'h0) [*4]
        |-> tsCount == $past(tsCount, 2) + 16'h0001) else $error("stamp not at half rate");
    a_store_hold: assert property (storeValid && !storeReady |=> storeValid
        && $stable(storeData)) else $error("record changed while stalled");
    a_clock_pick: assert property ((!sys_rst && $stable(canClockSourceSelect)) [*4]
        |-> canModuleClock == (canClockSourceSelect ? $past(mainCanClk, 3)
        : $past(xinCanClk, 3))) else $error("wrong clock source");
endmodule // can_rx_props
bind can_rx_dlc_mirror_timestamp can_rx_props chk (.clk(clk), .sys_rst(sys_rst),
    .dlcCheckEnable(dlcCheckEnable), .mirrorEnable(mirrorEnable),
    .canClockSourceSelect(canClockSourceSelect), .xinCanClk(xinCanClk), .mainCanClk(mainCanClk),
    .canModuleClock(canModuleClock), .tsSourceSel(tsSourceSel), .tsDivRatio(tsDivRatio),
    .tsChannelSel(tsChannelSel), .bitTimeTick(bitTimeTick), .chanResetMode(chanResetMode),
    .chanHaltMode(chanHaltMode), .tsCount(tsCount), .frameValid(frameValid),
    .frameReady(frameReady), .frameOwn(frameOwn), .frameDlc(frameDlc), .ruleDlc(ruleDlc),
    .ruleOwnMessageSelect(ruleOwnMessageSelect), .dlcError(dlcError), .ruleMiss(ruleMiss),
    .storeValid(storeValid), .storeReady(storeReady), .storeData(storeData));

// [test/can_node_model.sv]
// model of the bus side that hands finished frames to the block
`timescale 1ns/1ps
module can_node_model (
    input  wire        clk,
    input  wire        frameReady,
    output reg         frameValid,
    output reg         frameOwn,
    output reg  [28:0] frameId,
    output reg  [3:0]  frameDlc,
    output reg  [63:0] frameData,
    output reg         sofPulse
);
    initial
    begin
        {frameValid, frameOwn, frameId, frameDlc, frameData, sofPulse} = '0;
    end
    // start of frame, then one frame held until taken
    task send(input o, input [28:0] id, input [3:0] d, input [63:0] v);
        integer n;
        begin
            @(negedge clk);
            sofPulse = 1'b1;
            @(negedge clk);
            sofPulse = 1'b0;
            {frameValid, frameOwn, frameId, frameDlc, frameData} = {1'b1, o, id, d, v};
            n = 0;
            // ready is registered, so its level here is what the edge sees
            while (frameReady !== 1'b1 && n < 200)
            begin
                @(negedge clk);
                n = n + 1;
            end
            @(posedge clk);
            @(negedge clk);
            // released lines show the inverse, never a stale copy
            {frameValid, frameOwn, frameId, frameDlc, frameData} = {1'b0, ~o, ~id, ~d, ~v};
        end
    endtask
endmodule // can_node_model

// [test/tb.sv]
// self-checking bench for the receive dlc, mirror and timestamp block
`timescale 1ns/1ps
module tb;
    reg          clk, sys_rst, chk, rep, mir, clkSel, xin, mainC, tsSrc, rOwn, stR;
    reg  [3:0]   tsDiv, ruleDlc, bitTick, rstMode, haltMode;
    reg  [1:0]   tsSel;
    reg  [2:0]   ph;
    reg  [15:0]  lastStamp, t;
    reg  [127:0] expQ[$];
    wire         fV, fR, fOwn, sof, dlcErr, miss, sV, sOwn, modClk;
    wire [28:0]  fId, sId;
    wire [3:0]   fDlc, sDlc;
    wire [63:0]  fData, sData;
    wire [15:0]  tsCount, sStamp;
    integer      mismatches, testsRun, errSeen, missSeen, expErr, expMiss, k;
    can_node_model node (.clk(clk), .frameReady(fR), .frameValid(fV), .frameOwn(fOwn),
        .frameId(fId), .frameDlc(fDlc), .frameData(fData), .sofPulse(sof));
    can_rx_dlc_mirror_timestamp dut (.clk(clk), .sys_rst(sys_rst), .dlcCheckEnable(chk),
        .dlcReplaceEnable(rep), .mirrorEnable(mir), .canClockSourceSelect(clkSel),
        .xinCanClk(xin), .mainCanClk(mainC), .canModuleClock(modClk), .tsSourceSel(tsSrc),
        .tsDivRatio(tsDiv), .tsChannelSel(tsSel), .bitTimeTick(bitTick),
        .chanResetMode(rstMode), .chanHaltMode(haltMode), .sofPulse(sof), .tsCount(tsCount),
        .frameValid(fV), .frameReady(fR), .frameOwn(fOwn), .frameId(fId), .frameDlc(fDlc),
        .frameData(fData), .ruleDlc(ruleDlc), .ruleOwnMessageSelect(rOwn), .dlcError(dlcErr),
        .ruleMiss(miss), .storeValid(sV), .storeReady(stR), .storeStamp(sStamp), .storeId(sId),
        .storeOwn(sOwn), .storeDlc(sDlc), .storeData(sData));
    // ****
    // clocking and helpers
    // ****
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // bit ticks rotate one-hot, so each channel ticks every fourth clock
    always @(negedge clk)
    begin
        bitTick <= sys_rst ? 4'h1 : {bitTick[2:0], bitTick[3]};
        ph <= ph + 3'h1;
        xin <= ~xin;
        mainC <= ph[2];
    end
    task check(input [8*8-1:0] name, input [127:0] seen, input [127:0] exp);
        begin
            testsRun = testsRun + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // stamp taken at start of frame, pulses counted, records compared in order
    always @(posedge clk)
    begin
        if (sof)
            lastStamp <= tsCount;
        if (dlcErr)
            errSeen = errSeen + 1;
        if (miss)
            missSeen = missSeen + 1;
        if (sV && stR)
            check("record", {14'h0, sStamp, sId, sOwn, sDlc, sData},
                  expQ.size() ? expQ.pop_front() : 128'hX);
    end
    // offer one frame and work out what must come of it
    task send(input o, input [3:0] d, input [63:0] v);
        reg [63:0] m;
        integer i;
        begin
            node.send(o, {25'h0ABC123, d}, d, v);
            m = v;
            if (mir ? o !== rOwn : (o | rOwn))
                expMiss = expMiss + 1;
            else if (chk && ruleDlc != 4'h0 && d < ruleDlc)
                expErr = expErr + 1;
            else
            begin
                for (i = 0; i < 8; i = i + 1)
                    if (chk && rep && ruleDlc != 4'h0 && i >= ruleDlc)
                        m[i*8 +: 8] = 8'h00;
                expQ.push_back({14'h0, lastStamp, 25'h0ABC123, d, o,
                    (chk && rep && ruleDlc != 4'h0) ? ruleDlc : d, m});
            end
        end
    endtask
    task closeOut;
        begin
            $display("checks %0d mismatches %0d", testsRun, mismatches);
            if (mismatches == 0 && testsRun > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ****
    // scenarios
    // ****
    initial
    begin
        {chk, rep, mir, clkSel, xin, mainC, tsSrc, rOwn, ph, tsDiv, ruleDlc} = '0;
        {tsSel, rstMode, haltMode, lastStamp, errSeen, missSeen, expErr, expMiss} = '0;
        {mismatches, testsRun} = '0;
        bitTick = 4'h1;
        stR = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        // every check and replace pairing, below, at and above the rule dlc
        for (k = 0; k < 4; k = k + 1)
        begin
            {rep, chk} = k[1:0];
            ruleDlc = 4'h5;
            send(1'b0, 4'h4, 64'h8877665544332211);
            send(1'b0, 4'h5, 64'h8877665544332211);
            send(1'b0, 4'h9, 64'hF0E0D0C0B0A09080);
            ruleDlc = 4'h0;
            send(1'b0, 4'h2, 64'h0102030405060708);
        end
        // mirror on and off against own and foreign frames and both selects
        clkSel = 1'b1;
        ruleDlc = 4'h2;
        for (k = 0; k < 8; k = k + 1)
        begin
            {mir, rOwn} = k[1:0];
            send(k[2], 4'h8, 64'h1122334455667788);
        end
        repeat (8) @(negedge clk);
        check("dlcerr", errSeen, expErr);
        check("rulemiss", missSeen, expMiss);
        // stalled store side: fill until intake refuses, then drain to empty
        {stR, mir, rOwn, ruleDlc} = '0;
        for (k = 0; k < 18; k = k + 1)
            send(1'b0, k[3:0], {8{k[7:0]}});
        repeat (6) @(negedge clk);
        check("ready", fR, 1'b0);
        stR = 1'b1;
        repeat (60) @(negedge clk);
        check("left", expQ.size(), 0);
        check("valid", sV, 1'b0);
        // bit clock source stops in reset mode and in halt mode
        tsSrc = 1'b1;
        tsSel = 2'h2;
        for (k = 0; k < 2; k = k + 1)
        begin
            {rstMode, haltMode} = k ? 8'h04 : 8'h40;
            repeat (4) @(negedge clk);
            t = tsCount;
            repeat (10) @(negedge clk);
            check("halted", tsCount, t);
        end
        haltMode = 4'h0;
        t = tsCount;
        repeat (8) @(negedge clk);
        check("bittick", tsCount, t + 16'h2);
        // half pclk source ignores channel modes; divider of four
        {tsSrc, haltMode, rstMode} = 9'h0FF;
        repeat (4) @(negedge clk);
        t = tsCount;
        repeat (8) @(negedge clk);
        check("halfclk", tsCount, t + 16'h4);
        tsDiv = 4'h3;
        repeat (8) @(negedge clk);
        t = tsCount;
        repeat (16) @(negedge clk);
        check("divided", tsCount, t + 16'h2);
        closeOut;
    end
    // watchdog: the whole run needs about three hundred clocks
    initial
    begin
        #(40 * 8000);
        mismatches = mismatches + 1;
        closeOut;
    end
endmodule // tb
